// >>> core/deb_register_bank.sv
// Display engine register bank with host serial port and timing generator.
`timescale 1ns/10ps
// Notes on behaviour
// - frame_counter counts produced frames since reset.
// - cycle_counter counts system clocks since reset.
// - main_freq_hz resets 48 MHz, boot sets 60 MHz.
// - render_select picks full frame or single line.
// - scanline_select picks line for single-line mode.
// - capture trigger acts only in single-line mode.
// - capture_pixel_format six bits, resets to 20h.
// - engine_reset_ctrl holds audio, touch, graphics resets.
// - video CRC result updated on each list swap.
// - horizontal total, start, size with reset values.
// - hsync falls at first offset, rises second.
// - vertical total, start, size with reset values.
// - vsync falls at first line, rises second.
// - list_swap_ctrl governs when display list swaps.
// - screen_rotation selects orientation and mirroring.
// - output_depth three bits per channel, zero means eight.
// - colour_reorder selects RGB pin arrangement.
// - edge_spread_enable set at reset.
// - pixel_clock_polarity picks launch edge.
// - divider zero stops, one external sync, else divides.
// - query coordinates return touch tag result.
// - playback and synth volumes reset to FFh.
// - transfers open with read or write prefix.
module deb_register_bank
  import deb_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'hA5  // Arbitrary identity value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_mosi,
  input  wire logic [23:0] i_pixel,
  input  wire logic        i_ext_sync,
  input  wire logic [7:0]  i_tag_result,
  output logic             o_miso,
  output logic             o_miso_oe,
  output logic             o_hsync,
  output logic             o_vsync,
  output logic             o_de,
  output logic             o_pclk,
  output logic             o_list_swap,
  output logic [2:0]       o_engine_reset,
  output logic             o_render_single,
  output logic [10:0]      o_scanline,
  output logic             o_capture_start,
  output logic [5:0]       o_capture_format,
  output deb_disp_s        o_disp_cfg,
  output logic [10:0]      o_query_x,
  output logic [10:0]      o_query_y,
  output logic [7:0]       o_vol_playback,
  output logic [7:0]       o_vol_synth
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  function automatic logic [31:0] swap_bytes(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : swap_bytes

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : '0);
    end
    return r;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////
  // Host serial port, sampled in the system clock domain.

  logic [1:0]  cs_sync;
  logic [2:0]  sck_sync;
  logic [1:0]  mosi_sync;
  deb_spi_e    spi_state;
  logic [4:0]  bit_cnt;
  logic [31:0] shift_in;
  logic [31:0] shift_out;
  logic [21:0] addr;
  logic        load_pending;
  logic        wr_stb;
  logic [21:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_mux;

  wire         cs_act   = !cs_sync[1];
  wire         sck_rise = cs_act && sck_sync[1] && !sck_sync[2];
  wire         sck_fall = cs_act && !sck_sync[1] && sck_sync[2];
  wire  [31:0] next_shift = {shift_in[30:0], mosi_sync[1]};
  wire  [1:0]  cmd_prefix = next_shift[CMD_W-1 -: 2];
  wire         cmd_done = spi_state == SP_CMD && bit_cnt == 5'(CMD_W - 1);
  wire         dummy_done = spi_state == SP_DUMMY
                            && bit_cnt == 5'(BYTE_W - 1);
  wire         word_done = bit_cnt == 5'(WORD_W - 1);

  // The second and third stages feed the edge detector; the first stage only
  // settles metastability. SCK must stay below a quarter of the clock.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cs_sync   <= 2'h3;
      sck_sync  <= 3'h0;
      mosi_sync <= 2'h0;
    end else begin
      cs_sync   <= {cs_sync[0], i_cs_n};
      sck_sync  <= {sck_sync[1:0], i_sck};
      mosi_sync <= {mosi_sync[0], i_mosi};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || !cs_act) begin
      spi_state    <= SP_CMD;
      bit_cnt      <= '0;
      shift_in     <= '0;
      addr         <= '0;
      load_pending <= 1'b0;
      wr_stb       <= 1'b0;
    end else begin
      wr_stb       <= 1'b0;
      load_pending <= 1'b0;
      if (sck_rise) begin
        shift_in <= next_shift;
        bit_cnt  <= (cmd_done || dummy_done) ? '0 : bit_cnt + 5'h1;
        unique case (spi_state)
          SP_CMD: if (cmd_done) begin
            addr <= next_shift[ADDR_W-1:0];
            if (cmd_prefix == PFX_WRITE) begin
              spi_state <= SP_WRITE;
            end else if (cmd_prefix == PFX_READ) begin
              spi_state <= SP_DUMMY;
            end else begin
              spi_state <= SP_CMD;
            end
          end
          SP_DUMMY: if (dummy_done) begin
            spi_state    <= SP_READ;
            load_pending <= 1'b1;
          end
          SP_READ: if (word_done) begin
            addr         <= addr + A_STEP;
            load_pending <= 1'b1;
          end
          SP_WRITE: if (word_done) begin
            addr    <= addr + A_STEP;
            wr_stb  <= 1'b1;
            wr_addr <= addr;
            wr_data <= swap_bytes(next_shift);
          end
        endcase
      end
    end
  end

  // Reserved prefix 01 and 11 land back in SP_CMD and then ignore the rest
  // of the frame only by wrapping at every 24 bits; hosts must not use them.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      shift_out <= '0;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= cs_act;
      if (load_pending) begin
        shift_out <= swap_bytes(rd_mux);
      end else if (sck_fall && spi_state == SP_READ) begin
        o_miso    <= shift_out[31];
        shift_out <= {shift_out[30:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  deb_timing_s tmg;
  logic [31:0] frame_counter;
  logic [31:0] cycle_counter;
  logic [27:0] main_freq_hz;
  logic        boot_done;
  logic        line_capture_trigger;
  logic [31:0] video_crc_mask;
  logic [31:0] video_crc_result;
  logic [1:0]  list_swap_ctrl;
  logic        pixel_clock_polarity;
  logic [7:0]  pixel_clock_divider;
  logic [7:0]  query_result;
  logic        list_swap_event;
  logic        frame_end;
  logic [31:0] frame_crc;

  wire wr_on_swap = wr_stb && wr_addr == A_SWAP;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tmg                  <= TMG_RST;
      main_freq_hz         <= FREQ_RESET;
      boot_done            <= 1'b0;
      o_render_single      <= 1'b0;
      o_scanline           <= '0;
      line_capture_trigger <= 1'b0;
      o_capture_format     <= CAPFMT_RST;
      o_engine_reset       <= ENGRST_RST;
      video_crc_mask       <= MASK_RST;
      list_swap_ctrl       <= '0;
      o_disp_cfg           <= DISP_RST;
      pixel_clock_polarity <= 1'b0;
      pixel_clock_divider  <= DIV_STOP;
      o_query_x            <= '0;
      o_query_y            <= '0;
      o_vol_playback       <= VOL_RST;
      o_vol_synth          <= VOL_RST;
    end else begin
      if (!boot_done) begin
        boot_done    <= 1'b1;
        main_freq_hz <= FREQ_BOOT;
      end
      // A write that meets the hardware clear wins, so a request is kept.
      if (list_swap_event && !wr_on_swap) begin
        list_swap_ctrl <= '0;
      end
      if (wr_stb) begin
        // Identity, counters, CRC and tag result have no write case.
        unique case (wr_addr)
          A_FREQ:    main_freq_hz <= wr_data[27:0];
          A_RENDER:  o_render_single <= wr_data[0];
          A_SCANLN:  o_scanline <= wr_data[10:0];
          A_TRIGGER: line_capture_trigger <= wr_data[0];
          A_CAPFMT:  o_capture_format <= wr_data[5:0];
          A_ENGRST:  o_engine_reset <= wr_data[2:0];
          A_CRCMASK: video_crc_mask <= wr_data;
          A_HTOTAL:  tmg.h_total <= wr_data[11:0];
          A_HSTART:  tmg.h_start <= wr_data[11:0];
          A_HSIZE:   tmg.h_size <= wr_data[11:0];
          A_HFALL:   tmg.h_fall <= wr_data[11:0];
          A_HRISE:   tmg.h_rise <= wr_data[11:0];
          A_VTOTAL:  tmg.v_total <= wr_data[11:0];
          A_VSTART:  tmg.v_start <= wr_data[11:0];
          A_VSIZE:   tmg.v_size <= wr_data[11:0];
          A_VFALL:   tmg.v_fall <= wr_data[9:0];
          A_VRISE:   tmg.v_rise <= wr_data[9:0];
          A_SWAP:    list_swap_ctrl <= wr_data[1:0];
          A_ROTATE:  o_disp_cfg.rotation <= wr_data[2:0];
          A_DEPTH:   o_disp_cfg.depth <= wr_data[8:0];
          A_DITHER:  o_disp_cfg.dither <= wr_data[0];
          A_REORDER: o_disp_cfg.reorder <= wr_data[3:0];
          A_SPREAD:  o_disp_cfg.spread <= wr_data[0];
          A_PCLKPOL: pixel_clock_polarity <= wr_data[0];
          A_PCLKDIV: pixel_clock_divider <= wr_data[7:0];
          A_QX:      o_query_x <= wr_data[10:0];
          A_QY:      o_query_y <= wr_data[10:0];
          A_VOLPB:   o_vol_playback <= wr_data[7:0];
          A_VOLSYN:  o_vol_synth <= wr_data[7:0];
          default:   ;
        endcase
      end
    end
  end

  // Trigger is a pulse only while single-line mode is already selected.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_capture_start <= 1'b0;
      query_result    <= '0;
    end else begin
      o_capture_start <= wr_stb && wr_addr == A_TRIGGER && wr_data[0]
                         && o_render_single;
      if (!o_engine_reset[ENG_TOUCH]) begin
        query_result <= i_tag_result;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (addr)
      A_IDENT:   rd_mux = 32'(ID_CODE);
      A_FRAMES:  rd_mux = frame_counter;
      A_CYCLES:  rd_mux = cycle_counter;
      A_FREQ:    rd_mux = 32'(main_freq_hz);
      A_RENDER:  rd_mux = 32'(o_render_single);
      A_SCANLN:  rd_mux = 32'(o_scanline);
      A_TRIGGER: rd_mux = 32'(line_capture_trigger);
      A_CAPFMT:  rd_mux = 32'(o_capture_format);
      A_ENGRST:  rd_mux = 32'(o_engine_reset);
      A_CRC:     rd_mux = video_crc_result;
      A_CRCMASK: rd_mux = video_crc_mask;
      A_HTOTAL:  rd_mux = 32'(tmg.h_total);
      A_HSTART:  rd_mux = 32'(tmg.h_start);
      A_HSIZE:   rd_mux = 32'(tmg.h_size);
      A_HFALL:   rd_mux = 32'(tmg.h_fall);
      A_HRISE:   rd_mux = 32'(tmg.h_rise);
      A_VTOTAL:  rd_mux = 32'(tmg.v_total);
      A_VSTART:  rd_mux = 32'(tmg.v_start);
      A_VSIZE:   rd_mux = 32'(tmg.v_size);
      A_VFALL:   rd_mux = 32'(tmg.v_fall);
      A_VRISE:   rd_mux = 32'(tmg.v_rise);
      A_SWAP:    rd_mux = 32'(list_swap_ctrl);
      A_ROTATE:  rd_mux = 32'(o_disp_cfg.rotation);
      A_DEPTH:   rd_mux = 32'(o_disp_cfg.depth);
      A_DITHER:  rd_mux = 32'(o_disp_cfg.dither);
      A_REORDER: rd_mux = 32'(o_disp_cfg.reorder);
      A_SPREAD:  rd_mux = 32'(o_disp_cfg.spread);
      A_PCLKPOL: rd_mux = 32'(pixel_clock_polarity);
      A_PCLKDIV: rd_mux = 32'(pixel_clock_divider);
      A_QX:      rd_mux = 32'(o_query_x);
      A_QY:      rd_mux = 32'(o_query_y);
      A_QRES:    rd_mux = 32'(query_result);
      A_VOLPB:   rd_mux = 32'(o_vol_playback);
      A_VOLSYN:  rd_mux = 32'(o_vol_synth);
      default:   rd_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock, display timing, counters and video CRC.

  logic [7:0]  div_cnt;
  logic        pix_tick;
  logic [11:0] h_cnt;
  logic [11:0] v_cnt;
  logic [31:0] crc_acc;

  wire div_run  = pixel_clock_divider > DIV_EXT;
  wire div_last = div_cnt == pixel_clock_divider - 8'h1;
  wire next_tick = pixel_clock_divider == DIV_EXT ? i_ext_sync
                   : div_run && div_last;
  wire pclk_lvl = pixel_clock_divider == DIV_EXT ? i_ext_sync
                  : div_run && div_cnt < (pixel_clock_divider >> 1);
  wire h_wrap   = h_cnt >= tmg.h_total - 12'h1;
  wire v_wrap   = v_cnt >= tmg.v_total - 12'h1;
  wire h_act    = h_cnt >= tmg.h_start
                  && {1'b0, h_cnt} < {1'b0, tmg.h_start} + {1'b0, tmg.h_size};
  wire v_act    = v_cnt >= tmg.v_start
                  && {1'b0, v_cnt} < {1'b0, tmg.v_start} + {1'b0, tmg.v_size};
  wire swap_now = (list_swap_ctrl == SWAP_LINE && pix_tick && h_wrap)
                  || (list_swap_ctrl == SWAP_FRAME && pix_tick && h_wrap
                      && v_wrap);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      div_cnt  <= '0;
      pix_tick <= 1'b0;
      o_pclk   <= 1'b0;
    end else begin
      div_cnt  <= (!div_run || div_last) ? '0 : div_cnt + 8'h1;
      pix_tick <= next_tick;
      o_pclk   <= pclk_lvl ^ pixel_clock_polarity;
    end
  end

  // Sync edges are taken at the pixel tick, so horizontal offsets count pixel clocks and vertical offsets count lines.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      h_cnt <= '0;
      v_cnt <= '0;
      o_hsync <= 1'b1;
      o_vsync <= 1'b1;
      o_de <= 1'b0;
      frame_end <= 1'b0;
      frame_counter <= '0;
      cycle_counter <= '0;
      list_swap_event <= 1'b0;
      o_list_swap <= 1'b0;
      crc_acc <= CRC_SEED;
      frame_crc <= '0;
      video_crc_result <= '0;
    end else begin
      cycle_counter   <= cycle_counter + 32'h1;
      frame_end       <= pix_tick && h_wrap && v_wrap;
      list_swap_event <= swap_now;
      o_list_swap     <= swap_now;
      if (frame_end) begin
        frame_counter <= frame_counter + 32'h1;
      end
      if (pix_tick) begin
        h_cnt <= h_wrap ? '0 : h_cnt + 12'h1;
        if (h_wrap) begin
          v_cnt <= v_wrap ? '0 : v_cnt + 12'h1;
        end
        o_de <= h_act && v_act;
        if (h_cnt == tmg.h_fall) begin
          o_hsync <= 1'b0;
        end else if (h_cnt == tmg.h_rise) begin
          o_hsync <= 1'b1;
        end
        if (h_wrap && v_cnt == 12'(tmg.v_fall)) begin
          o_vsync <= 1'b0;
        end else if (h_wrap && v_cnt == 12'(tmg.v_rise)) begin
          o_vsync <= 1'b1;
        end
        if (h_wrap && v_wrap) begin
          frame_crc <= crc_acc;
          crc_acc   <= CRC_SEED;
        end else if (h_act && v_act) begin
          crc_acc <= crc_step(crc_acc, {8'h00, i_pixel} & video_crc_mask);
        end
      end
      if (list_swap_event) begin
        video_crc_result <= frame_crc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_cycle_count: assert property (
    $past(i_rstn) |-> cycle_counter == $past(cycle_counter) + 32'h1)
    else $error("cycle counter did not advance by one");
  chk_frame_count: assert property (
    frame_end |=> frame_counter == $past(frame_counter) + 32'h1)
    else $error("frame counter missed a frame end");
  chk_boot_freq: assert property (
    $rose(boot_done) |-> main_freq_hz == FREQ_BOOT)
    else $error("boot frequency not loaded");
  chk_capture_mode: assert property (
    o_capture_start |-> o_render_single)
    else $error("capture started outside single-line mode");
  chk_hsync_fall: assert property (
    pix_tick && h_cnt == tmg.h_fall |=> !o_hsync)
    else $error("hsync did not fall at its offset");
  chk_vsync_rise: assert property (
    pix_tick && h_wrap && v_cnt == 12'(tmg.v_rise)
    && v_cnt != 12'(tmg.v_fall) |=> o_vsync)
    else $error("vsync did not rise at its line");
  chk_crc_swap: assert property (
    swap_now ##1 !pix_tick |=> video_crc_result == $past(frame_crc))
    else $error("crc result not taken at list swap");
  chk_swap_clear: assert property (
    list_swap_event && !wr_on_swap |=> list_swap_ctrl == 2'h0)
    else $error("swap control not cleared after swap");
  chk_stop_clock: assert property (
    pixel_clock_divider == DIV_STOP |=> !pix_tick && div_cnt == 8'h00)
    else $error("pixel tick while divider stopped");

endmodule : deb_register_bank

// >>> core/deb_pkg.sv
// Package of addresses, reset values, enums and carriers for the register bank.
package deb_pkg;

  localparam int ADDR_W = 22;
  localparam int CMD_W  = 24;
  localparam int WORD_W = 32;
  localparam int BYTE_W = 8;

  localparam logic [1:0] PFX_READ  = 2'h0;
  localparam logic [1:0] PFX_WRITE = 2'h2;

  localparam logic [21:0] A_IDENT   = 22'h302000;
  localparam logic [21:0] A_FRAMES  = 22'h302004;
  localparam logic [21:0] A_CYCLES  = 22'h302008;
  localparam logic [21:0] A_FREQ    = 22'h30200C;
  localparam logic [21:0] A_RENDER  = 22'h302010;
  localparam logic [21:0] A_SCANLN  = 22'h302014;
  localparam logic [21:0] A_TRIGGER = 22'h302018;
  localparam logic [21:0] A_CAPFMT  = 22'h30201C;
  localparam logic [21:0] A_ENGRST  = 22'h302020;
  localparam logic [21:0] A_CRC     = 22'h302024;
  localparam logic [21:0] A_CRCMASK = 22'h302028;
  localparam logic [21:0] A_HTOTAL  = 22'h30202C;
  localparam logic [21:0] A_HSTART  = 22'h302030;
  localparam logic [21:0] A_HSIZE   = 22'h302034;
  localparam logic [21:0] A_HFALL   = 22'h302038;
  localparam logic [21:0] A_HRISE   = 22'h30203C;
  localparam logic [21:0] A_VTOTAL  = 22'h302040;
  localparam logic [21:0] A_VSTART  = 22'h302044;
  localparam logic [21:0] A_VSIZE   = 22'h302048;
  localparam logic [21:0] A_VFALL   = 22'h30204C;
  localparam logic [21:0] A_VRISE   = 22'h302050;
  localparam logic [21:0] A_SWAP    = 22'h302054;
  localparam logic [21:0] A_ROTATE  = 22'h302058;
  localparam logic [21:0] A_DEPTH   = 22'h30205C;
  localparam logic [21:0] A_DITHER  = 22'h302060;
  localparam logic [21:0] A_REORDER = 22'h302064;
  localparam logic [21:0] A_SPREAD  = 22'h302068;
  localparam logic [21:0] A_PCLKPOL = 22'h30206C;
  localparam logic [21:0] A_PCLKDIV = 22'h302070;
  localparam logic [21:0] A_QX      = 22'h302074;
  localparam logic [21:0] A_QY      = 22'h302078;
  localparam logic [21:0] A_QRES    = 22'h30207C;
  localparam logic [21:0] A_VOLPB   = 22'h302080;
  localparam logic [21:0] A_VOLSYN  = 22'h302084;
  localparam logic [21:0] A_STEP    = 22'h000004;

  localparam logic [27:0] FREQ_RESET = 28'h2DC6C00;
  localparam logic [27:0] FREQ_BOOT  = 28'h3938700;
  localparam logic [5:0]  CAPFMT_RST = 6'h20;
  localparam logic [2:0]  ENGRST_RST = 3'h2;
  localparam logic [31:0] MASK_RST   = 32'h0FFFFFFF;
  localparam logic [31:0] CRC_POLY   = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED   = 32'hFFFFFFFF;
  localparam logic [7:0]  VOL_RST    = 8'hFF;
  localparam logic [1:0]  SWAP_LINE  = 2'h1;
  localparam logic [1:0]  SWAP_FRAME = 2'h2;
  localparam logic [7:0]  DIV_STOP   = 8'h00;
  localparam logic [7:0]  DIV_EXT    = 8'h01;
  localparam int          ENG_TOUCH  = 1;

  typedef enum logic [1:0] {
    SP_CMD, SP_DUMMY, SP_READ, SP_WRITE
  } deb_spi_e;

  typedef struct packed {
    logic [11:0] h_total;
    logic [11:0] h_start;
    logic [11:0] h_size;
    logic [11:0] h_fall;
    logic [11:0] h_rise;
    logic [11:0] v_total;
    logic [11:0] v_start;
    logic [11:0] v_size;
    logic [9:0]  v_fall;
    logic [9:0]  v_rise;
  } deb_timing_s;

  localparam deb_timing_s TMG_RST = '{h_total: 12'h224, h_start: 12'h02B,
    h_size: 12'h1E0, h_fall: 12'h000, h_rise: 12'h029, v_total: 12'h124,
    v_start: 12'h00C, v_size: 12'h110, v_fall: 10'h000, v_rise: 10'h00A};

  typedef struct packed {
    logic [2:0] rotation;
    logic [8:0] depth;
    logic       dither;
    logic [3:0] reorder;
    logic       spread;
  } deb_disp_s;

  localparam deb_disp_s DISP_RST = '{rotation: 3'h0, depth: 9'h000,
    dither: 1'b1, reorder: 4'h0, spread: 1'b1};

endpackage : deb_pkg

// >>> testbench/deb_host_model.sv
// Host processor model driving the serial register port of the bank.
`timescale 1ns/10ps
module deb_host_model (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_mosi
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end
  // Phases of three clocks are the least the port's synchroniser accepts; four are used.
  task automatic xfer(input logic [23:0] cmd, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [63:0] sh;
    int          nb;
    nb = cmd[23] ? 56 : 64;
    sh = {cmd, 40'h0};
    if (cmd[23]) sh = {cmd, wd[7:0], wd[15:8], wd[23:16], wd[31:24], 8'h0};
    rd = 32'h0;
    @(posedge i_clk) #1 o_cs_n = 1'b0;
    for (int b = 0; b < nb; b++) begin
      o_mosi = sh[63-b];
      repeat (4) @(posedge i_clk);
      #1 o_sck = 1'b1;
      if (b >= 32) rd[8*((b-32)/8) + 7 - (b%8)] = i_miso;
      repeat (4) @(posedge i_clk);
      #1 o_sck = 1'b0;
    end
    repeat (4) @(posedge i_clk);
    #1 o_cs_n = 1'b1;
    // A released data line must not look like a held value.
    o_mosi = ~o_mosi;
    repeat (5) @(posedge i_clk);
    #1;
  endtask : xfer
endmodule : deb_host_model

// >>> testbench/tb_display_engine_register_bank.sv
// Self-checking bench for the display engine register bank.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_display_engine_register_bank;
  import deb_pkg::*;
  localparam logic [7:0] ID = 8'h3C;  // Arbitrary identity value.
  localparam logic [85:0] R [20] = '{
    {A_IDENT, 24'h0, ID, 32'h0}, {A_ENGRST, 32'h2, 32'h7},
    {A_FREQ, 4'h0, FREQ_BOOT, 32'h0FFFFFFF}, {A_RENDER, 32'h0, 32'h1},
    {A_SCANLN, 32'h0, 32'h7FF}, {A_CAPFMT, 32'h20, 32'h3F},
    {A_CRCMASK, 32'h0FFFFFFF, 32'hFFFFFFFF}, {A_HRISE, 32'h29, 32'hFFF},
    {A_VTOTAL, 32'h124, 32'hFFF}, {A_VRISE, 32'hA, 32'h3FF},
    {A_DEPTH, 32'h0, 32'h1FF}, {A_ROTATE, 32'h0, 32'h7},
    {A_REORDER, 32'h0, 32'hF}, {A_SPREAD, 32'h1, 32'h1},
    {A_PCLKPOL, 32'h0, 32'h1}, {A_QY, 32'h0, 32'h7FF},
    {A_QX, 32'h0, 32'h7FF},
    {A_VOLSYN, 32'hFF, 32'hFF}, {A_QRES, 32'h0, 32'h0},
    {A_VOLSYN + A_STEP, 32'h0, 32'h0}};
  localparam logic [53:0] S [11] = '{{A_HTOTAL, 32'hA}, {A_HSTART, 32'h2},
    {A_HSIZE, 32'h4}, {A_HFALL, 32'h0}, {A_HRISE, 32'h2}, {A_VTOTAL, 32'h6},
    {A_VSTART, 32'h1}, {A_VSIZE, 32'h3}, {A_VFALL, 32'h0}, {A_VRISE, 32'h1},
    {A_PCLKDIV, 32'h2}};
  localparam logic [31:0] W [2] = '{32'h5A5A5A5A, 32'hA5A5A5A5};
  logic i_clk, i_rstn, i_cs_n, i_sck, i_mosi, i_ext_sync, o_miso, o_miso_oe;
  logic o_hsync, o_vsync, o_de, o_pclk, o_list_swap, o_render_single;
  logic o_capture_start;
  logic [23:0] i_pixel;
  logic [7:0]  i_tag_result, o_vol_playback, o_vol_synth;
  logic [2:0]  o_engine_reset, mon;
  logic [10:0] o_scanline, o_query_x, o_query_y;
  logic [5:0]  o_capture_format;
  deb_disp_s   o_disp_cfg;
  int          bad_count, check_count, cyc, swaps, caps, oes;
  assign mon = {o_de, o_vsync, o_hsync};
  deb_register_bank #(.ID_CODE(ID)) dut (.*);
  deb_host_model host (.i_clk(i_clk), .i_miso(o_miso), .o_cs_n(i_cs_n),
                       .o_sck(i_sck), .o_mosi(i_mosi));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (o_list_swap === 1'b1) swaps++;
    if (o_capture_start === 1'b1) caps++;
    if (o_miso_oe === 1'b1 && i_cs_n === 1'b0) oes++;
  end
  task automatic wr(input logic [21:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer({PFX_WRITE, a}, d, x);
  endtask : wr
  task automatic rd(input logic [21:0] a, output logic [31:0] v);
    host.xfer({PFX_READ, a}, 32'h0, v);
  endtask : rd
  // Length of the next whole run of level l on one video output.
  task automatic span(input int k, input logic l, output int n);
    int t;
    n = 0;
    t = 0;
    while (mon[k] === l && t < 9000) begin @(negedge i_clk); t++; end
    while (mon[k] !== l && t < 9000) begin @(negedge i_clk); t++; end
    while (mon[k] === l && t < 9000) begin @(negedge i_clk); t++; n++; end
  endtask : span
  task automatic chg(output int n);
    logic p;
    n = 0;
    p = o_pclk;
    repeat (40) begin
      @(negedge i_clk);
      if (o_pclk !== p) n++;
      p = o_pclk;
    end
  endtask : chg
  task report_and_stop;
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (90000) @(posedge i_clk);
    bad_count++;
    report_and_stop;
  end
  initial begin
    logic [31:0] v, v2, e, m;
    logic [21:0] a;
    int          n, t0, t1;
    i_rstn = 1'b0;
    i_pixel = 24'h123456;
    i_ext_sync = 1'b0;
    i_tag_result = 8'h0;
    repeat (8) @(posedge i_clk);
    #1;
    `CHK("engines", 3'h2, o_engine_reset)
    `CHK("format", 6'h20, o_capture_format)
    `CHK("disp", 18'h00021, o_disp_cfg)
    `CHK("freq", FREQ_RESET, dut.main_freq_hz)
    `CHK("miso oe", 1'b0, o_miso_oe)
    `CHK("vol", 8'hFF, o_vol_playback)
    `CHK("vsync", 1'b1, o_vsync)
    i_rstn = 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int r = 0; r < 20; r++) begin
        a = R[r][85:64];
        e = R[r][63:32];
        m = R[r][31:0];
        if (p > 0) begin
          wr(a, W[p-1]);
          e = (W[p-1] & m) | (e & ~m);
        end
        rd(a, v);
        `CHK($sformatf("reg %h", a), e, v)
      end
    end
    `CHK("scanline", W[1][10:0], o_scanline)
    `CHK("capfmt", W[1][5:0], o_capture_format)
    `CHK("synth", W[1][7:0], o_vol_synth)
    `CHK("query y", W[1][10:0], o_query_y)
    `CHK("query x", W[1][10:0], o_query_x)
    `CHK("miso oe on", 1'b1, oes > 0)
    `CHK("render", W[1][0], o_render_single)
    `CHK("engines", W[1][2:0], o_engine_reset)
    `CHK("rotation", W[1][2:0], o_disp_cfg.rotation)
    `CHK("depth", W[1][8:0], o_disp_cfg.depth)
    t0 = cyc;
    rd(A_CYCLES, v);
    t1 = cyc;
    rd(A_CYCLES, v2);
    `CHK("cycles", t1 - t0, v2 - v)
    wr(A_RENDER, 32'h0);
    n = caps;
    wr(A_TRIGGER, 32'h1);
    `CHK("no capture", n, caps)
    wr(A_RENDER, 32'h1);
    wr(A_TRIGGER, 32'h1);
    `CHK("capture", n + 1, caps)
    wr(A_ENGRST, 32'h0);
    i_tag_result = 8'hC3;
    rd(A_QRES, v);
    `CHK("tag", 32'hC3, v)
    chg(n);
    `CHK("pclk stopped", 0, n)
    for (int s = 0; s < 11; s++) wr(S[s][53:32], S[s][31:0]);
    chg(n);
    `CHK("pclk running", 39, n)
    span(0, 1'b0, n);
    `CHK("hsync low", 4, n)
    span(2, 1'b1, n);
    `CHK("de high", 8, n)
    span(1, 1'b0, n);
    `CHK("vsync low", 20, n)
    t0 = cyc;
    rd(A_FRAMES, v);
    t1 = cyc;
    rd(A_FRAMES, v2);
    n = (t1 - t0) / 120;
    `CHK("frames", 1'b1, (v2 - v >= n && v2 - v <= n + 1))
    for (int c = 1; c < 3; c++) begin
      n = swaps;
      wr(A_SWAP, 32'(c));
      rd(A_SWAP, v);
      `CHK("swap clear", 32'h0, v)
      `CHK("swap pulse", n + 1, swaps)
    end
    report_and_stop;
  end
endmodule : tb_display_engine_register_bank
